// ---- rtl/cdw_pkg.sv ----
// constants and field layout of the serial write port of the current converter
//
// Functional notes
// - 24-bit input shift register, MSB first, sampled on shift-clock rising edges.
// - word is 8-bit address field above a 16-bit payload field.
// - shifting ignores the load strobe; strobe rise commits the latest 24 bits (code: more than 24 edges also gives an invalid word).
// - address 0 no-op; 01 data, 55 control, 56 reset register writes.
// - address 02 arms readback of the register picked by read-address bits.
// - first rising edge capturing the MSB starts a write cycle.
// - strobe before the 24th edge gives an invalid word, no update promised.
// - top 4 code bits drive 15 segment switches; rest drive ladder switches.
// - read address 00 status, 01 conversion data, 10 control register.
// - after readback host sends no-op; selected data shifts out on falling edges.
// - serial output tri-stated by default; enabled by readback commit, off next commit.
// - reset clears every register to zero, output disabled.
package cdw_pkg;

  // word layout
  localparam int WORD_W    = 24;
  localparam int ADDR_W    = 8;
  localparam int PAY_W     = 16;
  localparam int ADDR_LSB  = 16;
  localparam int SEG_BITS  = 4;
  localparam int SEG_N     = 15;
  localparam int CNT_W     = 8;

  // address field codes
  localparam logic [ADDR_W-1:0] ADDR_NOP   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DATA  = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_READ  = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h55;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h56;

  // read-address field sits in payload bits 1:0
  localparam int RD_SEL_LSB = 0;
  localparam logic [1:0] RD_STATUS = 2'h0;
  localparam logic [1:0] RD_DATA   = 2'h1;
  localparam logic [1:0] RD_CTRL   = 2'h2;

  // soft reset trigger bit, status bit positions
  localparam int SOFT_RST_BIT   = 0;
  localparam int STAT_WORD_ERR  = 0;

  // reset values
  localparam logic [PAY_W-1:0]  REG_RESET  = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 8'h00;
  localparam logic [CNT_W-1:0]  EDGES_PER_WORD = 8'h18;

  // readback state, gray coded
  typedef enum logic [1:0] {
    CDW_RB_IDLE  = 2'b00,
    CDW_RB_ARMED = 2'b01
  } cdw_rb_state_t;

endpackage : cdw_pkg

// ---- rtl/cdw_write_port.sv ----
// serial write port: shift register on the shift clock, decode and registers on mclk
module cdw_write_port
  import cdw_pkg::*;
#(
  parameter int RES_BITS = 16
) (
  // system clock domain
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // serial link pins
  input  wire logic                  sclk,
  input  wire logic                  serial_input,
  input  wire logic                  load_strobe,
  output logic                       serial_output,
  output logic                       serial_output_en,
  // converter core switches
  output logic [SEG_N-1:0]           segment_switches,
  output logic [RES_BITS-SEG_BITS-1:0] ladder_switches,
  // register contents and status
  output logic [PAY_W-1:0]           conversion_code,
  output logic [PAY_W-1:0]           output_configuration,
  output logic                       word_error,
  output logic                       commit_pulse
);

  localparam int LAD_W = RES_BITS - SEG_BITS;

  if (RES_BITS != 12 && RES_BITS != 16) begin : g_res_check
    $error("cdw_write_port: RES_BITS must be 12 or 16");
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  function automatic logic [SEG_N-1:0] thermo(input logic [SEG_BITS-1:0] v);
    logic [SEG_N-1:0] t;
    for (int i = 0; i < SEG_N; i++) begin
      t[i] = (32'(v) > i);
    end
    thermo = t;
  endfunction : thermo

  //////////////////////////////////////////////////////////////////////////////
  // link domain: reset synchroniser

  logic lrst_s1;
  logic lrst_s2;

  always_ff @(posedge sclk) begin
    lrst_s1 <= sys_rst;
    lrst_s2 <= lrst_s1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: input shift register and free-running edge counter

  logic [WORD_W-1:0] shift_reg;
  logic [CNT_W-1:0]  edge_cnt;
  logic [CNT_W-1:0]  edge_gray;
  logic [WORD_W-1:0] next_shift_reg;
  logic [CNT_W-1:0]  next_edge_cnt;
  logic [CNT_W-1:0]  next_edge_gray;

  // the counter is never cleared by the strobe; the system side measures
  // edges per word as a difference, so no event has to cross into sclk
  always_comb begin
    next_shift_reg = {shift_reg[WORD_W-2:0], serial_input};
    next_edge_cnt  = edge_cnt + 8'h01;
    next_edge_gray = bin2gray(next_edge_cnt);
    if (lrst_s2) begin
      next_shift_reg = WORD_RESET;
      next_edge_cnt  = CNT_RESET;
      next_edge_gray = CNT_RESET;
    end
  end

  always_ff @(posedge sclk) begin
    shift_reg <= next_shift_reg;
    edge_cnt  <= next_edge_cnt;
    edge_gray <= next_edge_gray;
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: strobe and counter synchronisers

  logic             strobe_s1;
  logic             strobe_s2;
  logic             strobe_s3;
  logic [CNT_W-1:0] gray_s1;
  logic [CNT_W-1:0] gray_s2;
  logic             next_strobe_s1;
  logic             next_strobe_s2;
  logic             next_strobe_s3;
  logic [CNT_W-1:0] next_gray_s1;
  logic [CNT_W-1:0] next_gray_s2;

  always_comb begin
    next_strobe_s1 = load_strobe;
    next_strobe_s2 = strobe_s1;
    next_strobe_s3 = strobe_s2;
    next_gray_s1   = edge_gray;
    next_gray_s2   = gray_s1;
    if (sys_rst) begin
      next_strobe_s1 = 1'b0;
      next_strobe_s2 = 1'b0;
      next_strobe_s3 = 1'b0;
      next_gray_s1   = CNT_RESET;
      next_gray_s2   = CNT_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || clk_en) begin
      strobe_s1 <= next_strobe_s1;
      strobe_s2 <= next_strobe_s2;
      strobe_s3 <= next_strobe_s3;
      gray_s1   <= next_gray_s1;
      gray_s2   <= next_gray_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: commit decode and registers

  logic                 commit;
  logic [CNT_W-1:0]     cnt_now;
  logic [CNT_W-1:0]     edges;
  logic                 word_ok;
  logic [ADDR_W-1:0]    cmd_addr;
  logic [PAY_W-1:0]     cmd_pay;
  logic [PAY_W-1:0]     status_reg;
  logic [PAY_W-1:0]     rd_value;

  logic [CNT_W-1:0]     cnt_base;
  logic [WORD_W-1:0]    rb_word;
  cdw_rb_state_t        rb_state;
  logic                 next_commit_pulse;
  logic [PAY_W-1:0]     next_conversion_code;
  logic [PAY_W-1:0]     next_output_configuration;
  logic                 next_word_error;
  logic [CNT_W-1:0]     next_cnt_base;
  logic [WORD_W-1:0]    next_rb_word;
  cdw_rb_state_t        next_rb_state;
  logic [SEG_N-1:0]     next_segment_switches;
  logic [LAD_W-1:0]     next_ladder_switches;

  // the shift register is read directly: it is still while the strobe is
  // seen, because the host stops or pauses the clock around the strobe
  assign commit   = strobe_s2 & ~strobe_s3;
  assign cnt_now  = gray2bin(gray_s2);
  assign edges    = cnt_now - cnt_base;
  assign word_ok  = (edges == EDGES_PER_WORD);
  assign cmd_addr = shift_reg[ADDR_LSB +: ADDR_W];
  assign cmd_pay  = shift_reg[PAY_W-1:0];

  always_comb begin
    status_reg = REG_RESET;
    status_reg[STAT_WORD_ERR] = word_error;
  end

  always_comb begin
    case (cmd_pay[RD_SEL_LSB +: 2])
      RD_STATUS: rd_value = status_reg;
      RD_DATA:   rd_value = conversion_code;
      RD_CTRL:   rd_value = output_configuration;
      default:   rd_value = REG_RESET;
    endcase
  end

  always_comb begin
    next_commit_pulse         = commit;
    next_conversion_code      = conversion_code;
    next_output_configuration = output_configuration;
    next_word_error           = word_error;
    next_cnt_base             = cnt_base;
    next_rb_word              = rb_word;
    next_rb_state             = rb_state;
    if (commit) begin
      next_cnt_base = cnt_now;
      // the output is released on every commit; a readback re-arms it below
      next_rb_state = CDW_RB_IDLE;
      if (!word_ok) begin
        next_word_error = 1'b1;
      end else begin
        next_word_error = 1'b0;
        case (cmd_addr)
          ADDR_NOP: begin
            next_rb_word = rb_word;
          end
          ADDR_DATA: begin
            next_conversion_code = cmd_pay;
          end
          ADDR_CTRL: begin
            next_output_configuration = cmd_pay;
          end
          ADDR_RESET: begin
            if (cmd_pay[SOFT_RST_BIT]) begin
              next_conversion_code      = REG_RESET;
              next_output_configuration = REG_RESET;
              next_rb_word              = WORD_RESET;
            end
          end
          ADDR_READ: begin
            next_rb_word  = {ADDR_NOP, rd_value};
            next_rb_state = CDW_RB_ARMED;
          end
          default: begin
            next_rb_word = rb_word;
          end
        endcase
      end
    end
    next_segment_switches = thermo(next_conversion_code[PAY_W-1 -: SEG_BITS]);
    next_ladder_switches  = next_conversion_code[PAY_W-SEG_BITS-1 -: LAD_W];
    if (sys_rst) begin
      next_commit_pulse         = 1'b0;
      next_conversion_code      = REG_RESET;
      next_output_configuration = REG_RESET;
      next_word_error           = 1'b0;
      next_cnt_base             = CNT_RESET;
      next_rb_word              = WORD_RESET;
      next_rb_state             = CDW_RB_IDLE;
      next_segment_switches     = '0;
      next_ladder_switches      = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || clk_en) begin
      commit_pulse         <= next_commit_pulse;
      conversion_code      <= next_conversion_code;
      output_configuration <= next_output_configuration;
      word_error           <= next_word_error;
      cnt_base             <= next_cnt_base;
      rb_word              <= next_rb_word;
      rb_state             <= next_rb_state;
      segment_switches     <= next_segment_switches;
      ladder_switches      <= next_ladder_switches;
    end
  end

  assign serial_output_en = (rb_state == CDW_RB_ARMED);

  //////////////////////////////////////////////////////////////////////////////
  // link domain: readback shift-out on falling edges

  // rb_word and cnt_base only change at a commit and then stay still for the
  // whole following transfer, so the link side may read them as static words
  logic [CNT_W-1:0] out_pos;
  logic             out_bit;
  logic             next_out_bit;
  logic [4:0]       out_idx;

  assign out_pos = edge_cnt - cnt_base;

  always_comb begin
    out_idx      = 5'(WORD_W - 1);
    next_out_bit = 1'b0;
    if (out_pos < EDGES_PER_WORD) begin
      out_idx      = 5'(WORD_W - 1) - out_pos[4:0];
      next_out_bit = rb_word[out_idx];
    end
    if (lrst_s2) begin
      next_out_bit = 1'b0;
    end
  end

  always_ff @(negedge sclk) begin
    out_bit <= next_out_bit;
  end

  // before the first rising edge of a transfer the MSB is presented directly,
  // so it is valid at the first rising edge
  assign serial_output = (out_pos == CNT_RESET) ? rb_word[WORD_W-1] : out_bit;

endmodule : cdw_write_port

// ---- test/cdw_host_model.sv ----
// host model: shifts words into the port and collects readback bits
module cdw_host_model (
  // link pins driven by the host
  output logic      sclk,
  output logic      serial_input,
  output logic      load_strobe,
  // readback pin
  input  wire logic serial_output
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    serial_input = 1'b0;
    load_strobe = 1'b0;
  end
  // free edges, only while reset is held so the link domain resets too
  task automatic idle(input int n);
    repeat (n) begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask : idle
  // n rising edges, then the strobe; sclk stays still outside the burst
  task automatic send(input logic [23:0] w, input int n, output logic [23:0] rd);
    rd = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      #5 serial_input = w[i % 24];
      #19 sclk = 1'b1;
      rd = {rd[22:0], serial_output};
      #24 sclk = 1'b0;
    end
    #5 serial_input = ~serial_input;
    #15 load_strobe = 1'b1;
    #60 load_strobe = 1'b0;
    #100;
  endtask : send
endmodule : cdw_host_model

// ---- test/cdw_write_port_chk.sv ----
// assertion checker for the serial write port, bound to its top module
module cdw_write_port_chk
  import cdw_pkg::*;
#(
  parameter int RES_BITS = 16
) (
  // clock and reset
  input wire logic                          mclk,
  input wire logic                          sys_rst,
  input wire logic                          clk_en,
  // watched outputs
  input wire logic                          serial_output_en,
  input wire logic [SEG_N-1:0]              segment_switches,
  input wire logic [RES_BITS-SEG_BITS-1:0]  ladder_switches,
  input wire logic [PAY_W-1:0]              conversion_code,
  input wire logic [PAY_W-1:0]              output_configuration,
  input wire logic                          word_error,
  input wire logic                          commit_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  seg_thermo_a: assert property (
    segment_switches == SEG_N'((17'h1 << conversion_code[15:12]) - 17'h1))
    else $error("segment switches disagree with code");
  ladder_copy_a: assert property (
    ladder_switches == conversion_code[PAY_W-SEG_BITS-1 -: RES_BITS-SEG_BITS])
    else $error("ladder switches disagree with code");
  code_hold_a: assert property (
    !commit_pulse |-> $stable(conversion_code))
    else $error("code moved without a commit");
  cfg_hold_a: assert property (
    !commit_pulse |-> $stable(output_configuration))
    else $error("configuration moved without a commit");
  // a frozen clock enable may stretch the pulse, so it is only judged when enabled
  pulse_single_a: assert property (
    commit_pulse && clk_en |=> !commit_pulse)
    else $error("commit pulse too long");
  en_at_commit_a: assert property (
    $changed(serial_output_en) |-> commit_pulse)
    else $error("output enable moved without a commit");
  err_at_commit_a: assert property (
    $changed(word_error) |-> commit_pulse)
    else $error("word error moved without a commit");
  bad_no_write_a: assert property (
    commit_pulse && word_error |-> $stable(conversion_code) && $stable(output_configuration))
    else $error("invalid word changed a register");
  bad_no_read_a: assert property (
    commit_pulse && word_error |-> !serial_output_en)
    else $error("invalid word left output driven");
  cover property (commit_pulse && word_error);
  cover property ($rose(serial_output_en));
  cover property (segment_switches == 15'h7FFF);
endmodule : cdw_write_port_chk

bind cdw_write_port cdw_write_port_chk #(.RES_BITS(RES_BITS)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .serial_output_en(serial_output_en),
  .segment_switches(segment_switches), .ladder_switches(ladder_switches),
  .conversion_code(conversion_code), .output_configuration(output_configuration),
  .word_error(word_error), .commit_pulse(commit_pulse));

// ---- test/tb_top.sv ----
// self-checking bench for the serial write port against an integer model
module tb_top
  import cdw_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, sys_rst, clk_en, sclk, serial_input, load_strobe;
  logic        serial_output, serial_output_en, word_error, commit_pulse;
  logic [14:0] segment_switches;
  logic [11:0] ladder_switches;
  logic [15:0] conversion_code, output_configuration, m_code, m_cfg, m_rb, p;
  logic        m_err, m_en, pend, pr;
  logic [16:0] lf = 17'h12695;
  logic [23:0] rd;
  logic [7:0]  bad_a [4] = '{8'h00, 8'h03, 8'h54, 8'hFF};
  int          n_fail, tests_run;
  wire         sdo_pin;
  ////////////////////////////////////////
  cdw_write_port #(.RES_BITS(16)) u_cdw_write_port (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .sclk(sclk),
    .serial_input(serial_input), .load_strobe(load_strobe),
    .serial_output(serial_output), .serial_output_en(serial_output_en),
    .segment_switches(segment_switches), .ladder_switches(ladder_switches),
    .conversion_code(conversion_code), .output_configuration(output_configuration),
    .word_error(word_error), .commit_pulse(commit_pulse));
  assign sdo_pin = serial_output_en ? serial_output : 1'bz;
  cdw_host_model u_cdw_host_model (.sclk(sclk), .serial_input(serial_input),
    .load_strobe(load_strobe), .serial_output(sdo_pin));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    lfsr_next = {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr_next
  // random stalls of the clock enable; commits must still land
  always @(posedge mclk) begin
    #2;
    lf = lfsr_next(lf);
    clk_en = sys_rst | (lf[1:0] != 2'h0);
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  always @(negedge mclk) begin
    if (commit_pulse && !pr && pend) begin
      chk("code", conversion_code, m_code);
      chk("config", output_configuration, m_cfg);
      chk("error", word_error, m_err);
      chk("enable", serial_output_en, m_en);
      chk("segments", segment_switches, 15'((16'h1 << m_code[15:12]) - 16'h1));
      chk("ladder", ladder_switches, m_code[11:0]);
      pend = 1'b0;
    end
    pr = commit_pulse;
  end
  task automatic xfer(input logic [23:0] w, input int n);
    p = w[15:0];
    m_en = 1'b0;
    if (n == 24) begin
      case (w[23:16])
        ADDR_DATA: m_code = p;
        ADDR_CTRL: m_cfg = p;
        ADDR_RESET: if (p[0]) {m_code, m_cfg} = 32'h00000000;
        ADDR_READ: begin
          m_en = 1'b1;
          m_rb = (p[1:0] == RD_DATA) ? m_code : (p[1:0] == RD_CTRL) ? m_cfg : 16'h0000;
          if (p[1:0] == RD_STATUS) m_rb = {15'h0000, m_err};
        end
        default: ;
      endcase
    end
    // status shows the verdict on the word before this one
    m_err = (n != 24);
    pend = 1'b1;
    u_cdw_host_model.send(w, n, rd);
    for (int i = 0; i < 100 && pend; i++) @(negedge mclk);
    if (pend) begin
      n_fail++;
      conclude();
    end
  endtask : xfer
  ////////////////////////////////////////
  initial begin
    {n_fail, tests_run} = 64'h0;
    {sys_rst, clk_en, pend, pr, m_err, m_en} = 6'h30;
    {m_code, m_cfg, m_rb} = 48'h0;
    // link domain needs sclk edges inside reset, so reset outlasts four sclk cycles
    fork
      u_cdw_host_model.idle(4);
    join_none
    repeat (21) @(posedge mclk);
    #2 sys_rst = 1'b0;
    chk("reset code", conversion_code, 24'h0);
    chk("reset enable", serial_output_en, 24'h0);
    // the link reset only lets go on sclk edges; these two are still reset edges
    u_cdw_host_model.idle(2);
    xfer(24'h01F000, 24);
    xfer(24'h010FFF, 24);
    repeat (5) xfer({8'h01, lf[15:0]}, 24);
    foreach (bad_a[k]) xfer({bad_a[k], lf[15:0]}, 24);
    xfer({8'h01, lf[15:0]}, 23);
    xfer({8'h55, lf[15:0]}, 25);
    for (int s = 3; s >= 0; s--) begin
      xfer({8'h55, lf[15:0]}, 24);
      xfer({14'h0080, 8'h00, 2'(s)}, 24);
      xfer(24'h000000, 24);
      chk("readback", rd, {8'h00, m_rb});
    end
    xfer(24'h020001, 24);
    xfer(24'h000000, 20);
    xfer(24'h560000, 24);
    xfer(24'h560001, 24);
    conclude();
  end
endmodule : tb_top
